/* src/sfbc_fifo.sv */
`timescale 1ns/1ps
module sfbc_fifo
    import sfbc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 512,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear,
    input wire logic [AW:0] capacity,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q < capacity;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
    assign count = cnt_q;
    // a full buffer refuses the byte, contents untouched
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || clear) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= AW'(wp_q + 1'b1);
            end
            if (pop) begin
                rp_q <= AW'(rp_q + 1'b1);
            end
            cnt_q <= (AW+1)'(cnt_q + push - pop);
        end
    end
endmodule

/* src/sfbc_pkg.sv */
package sfbc_pkg;
    // register indices on the host register port
    localparam logic [7:0] SFBC_CTRL_ADDR = 8'h02;
    localparam logic [7:0] SFBC_THR_LOW_ADDR = 8'h03;
    localparam logic [7:0] SFBC_FILL_ADDR = 8'h04;
    localparam logic [7:0] SFBC_DATA_ADDR = 8'h05;
    localparam logic [7:0] SFBC_INTERRUPT_STATUS_REG0_ADDR = 8'h06;
    localparam logic [7:0] SFBC_INTERRUPT_STATUS_REG0_EN_ADDR = 8'h08;
    // buffer_control_reg fields
    localparam int SFBC_CLEAR_BIT = 4;
    localparam int SFBC_SIZE_BIT = 7;
    localparam int SFBC_FULL_FLAG_BIT = 6;
    localparam int SFBC_EMPTY_FLAG_BIT = 5;
    localparam int SFBC_THR_HI_BIT = 2;
    localparam int SFBC_FILL_HI_BIT = 0;
    // a full 512-byte buffer needs a tenth count bit
    localparam int SFBC_FILL_TOP_BIT = 1;
    // interrupt_status_reg0 / interrupt_enable_reg0 fields
    localparam int SFBC_IRQ_SET_BIT = 7;
    localparam int SFBC_IRQ_FULL_BIT = 3;
    localparam int SFBC_IRQ_EMPTY_BIT = 2;
    localparam int SFBC_IRQ_ERR_BIT = 1;
    localparam int SFBC_IRQ_OVR_BIT = 0;
    // reset values
    localparam logic [7:0] SFBC_CTRL_RST = 8'h00;
    localparam logic [8:0] SFBC_THR_RST = 9'h008;
    localparam logic [7:0] SFBC_IRQ_RST = 8'h00;
    // capacities
    localparam logic [9:0] SFBC_CAP_LARGE = 10'h200;
    localparam logic [9:0] SFBC_CAP_SMALL = 10'h0ff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfbc_req_t;

    typedef struct packed {
        logic full;
        logic empty;
        logic overrun;
    } sfbc_flags_t;
endpackage

/* src/sfbc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - The command engine reads and writes the buffer alongside host accesses.
// - Writing 1 to the clear bit resets both pointers and the count, hiding old bytes.
// - Capacity is 512 bytes, or 255 when the size bit is 1, refillable after a clear.
// - The count rises per byte written and falls per byte read, its top two bits in control.
// - One threshold serves both alerts, from the top for full and bottom for empty.
// - The threshold is control bit 2 above the eight bits of the threshold register.
// - Almost-full reads 1 when capacity minus count is at most the threshold.
// - Almost-empty reads 1 when the count is at most the threshold.
// - Writing a full buffer sets the overrun flag and the error interrupt bit.
// - With its enable set, a rising almost-empty flag raises the interrupt pin.
// - With its enable set, a rising almost-full flag raises the interrupt pin.
// - In 255 mode the count uses one byte, in 512 mode two; the threshold always has nine bits.
module sfbc_top
    import sfbc_pkg::*;
#(
    parameter int DEPTH = 512
) (
    input wire logic clock,
    input wire logic resetn,
    input wire sfbc_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_rd,
    output logic cmd_rd_ok,
    output logic [7:0] cmd_rdata,
    output logic cmd_full,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);

    logic size_small_q;
    logic [8:0] thr_q;
    logic [7:0] irq_en_q;
    logic full_irq_q;
    logic empty_irq_q;
    logic err_irq_q;
    logic overrun_q;
    logic full_prev_q;
    logic empty_prev_q;
    logic [7:0] host_rdata_q;
    logic host_rvalid_q;
    logic [7:0] cmd_rdata_q;
    logic cmd_rd_ok_q;
    logic cmd_full_q;
    logic irq_q;

    logic host_wr_ctrl;
    logic clear;
    logic host_push;
    logic host_pop;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [7:0] out_data;
    logic [AW:0] count;
    logic [AW:0] capacity;
    logic [AW:0] free_space;
    logic almost_full_flag;
    logic almost_empty_flag;
    logic overrun_evt;
    sfbc_flags_t flags;

    assign host_wr_ctrl = host_req.wr && host_req.addr == SFBC_CTRL_ADDR;
    assign clear = host_wr_ctrl && host_req.wdata[SFBC_CLEAR_BIT];
    assign host_push = host_req.wr && host_req.addr == SFBC_DATA_ADDR;
    assign host_pop = host_req.rd && host_req.addr == SFBC_DATA_ADDR;

    // shared port arbitration; host data access wins the cycle
    assign in_valid = host_push || cmd_wr;
    assign in_data = host_push ? host_req.wdata : cmd_wdata;
    assign out_ready = host_pop || (cmd_rd && !host_pop);

    assign capacity = size_small_q ? (AW+1)'(SFBC_CAP_SMALL) : (AW+1)'(SFBC_CAP_LARGE);
    assign free_space = (AW+1)'(capacity - count);
    assign almost_full_flag = free_space <= (AW+1)'(thr_q);
    assign almost_empty_flag = count <= (AW+1)'(thr_q);
    assign overrun_evt = in_valid && !in_ready && !clear;
    assign flags = '{full: almost_full_flag, empty: almost_empty_flag, overrun: overrun_evt};

    sfbc_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .clear(clear),
        .capacity(capacity),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data),
        .count(count)
    );

    always_ff @(posedge clock) begin
        if (!resetn) begin
            size_small_q <= 1'b0;
            thr_q <= SFBC_THR_RST;
        end else begin
            if (host_wr_ctrl) begin
                size_small_q <= host_req.wdata[SFBC_SIZE_BIT];
                thr_q[8] <= host_req.wdata[SFBC_THR_HI_BIT];
            end
            if (host_req.wr && host_req.addr == SFBC_THR_LOW_ADDR) begin
                thr_q[7:0] <= host_req.wdata;
            end
        end
    end

    // sticky status; a same-cycle event beats the host clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_en_q <= SFBC_IRQ_RST;
            full_irq_q <= 1'b0;
            empty_irq_q <= 1'b0;
            err_irq_q <= 1'b0;
            overrun_q <= 1'b0;
            full_prev_q <= 1'b0;
            empty_prev_q <= 1'b1;
        end else begin
            full_prev_q <= flags.full;
            empty_prev_q <= flags.empty;
            if (host_req.wr && host_req.addr == SFBC_INTERRUPT_STATUS_REG0_EN_ADDR) begin
                irq_en_q <= host_req.wdata;
            end
            if (host_req.wr && host_req.addr == SFBC_INTERRUPT_STATUS_REG0_ADDR &&
                    !host_req.wdata[SFBC_IRQ_SET_BIT]) begin
                if (host_req.wdata[SFBC_IRQ_FULL_BIT]) begin
                    full_irq_q <= 1'b0;
                end
                if (host_req.wdata[SFBC_IRQ_EMPTY_BIT]) begin
                    empty_irq_q <= 1'b0;
                end
                if (host_req.wdata[SFBC_IRQ_ERR_BIT]) begin
                    err_irq_q <= 1'b0;
                end
            end
            if (clear) begin
                overrun_q <= 1'b0;
            end
            if (flags.full && !full_prev_q) begin
                full_irq_q <= 1'b1;
            end
            if (flags.empty && !empty_prev_q) begin
                empty_irq_q <= 1'b1;
            end
            if (flags.overrun) begin
                overrun_q <= 1'b1;
                err_irq_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (full_irq_q && irq_en_q[SFBC_IRQ_FULL_BIT]) ||
                     (empty_irq_q && irq_en_q[SFBC_IRQ_EMPTY_BIT]) ||
                     (err_irq_q && irq_en_q[SFBC_IRQ_ERR_BIT]);
        end
    end

    // fill count split across two bytes
    always_ff @(posedge clock) begin
        if (!resetn) begin
            host_rdata_q <= 8'h00;
            host_rvalid_q <= 1'b0;
        end else begin
            host_rvalid_q <= host_req.rd;
            host_rdata_q <= 8'h00;
            if (host_req.rd) begin
                case (host_req.addr)
                    SFBC_CTRL_ADDR: begin
                        host_rdata_q <= SFBC_CTRL_RST;
                        host_rdata_q[SFBC_SIZE_BIT] <= size_small_q;
                        host_rdata_q[SFBC_FULL_FLAG_BIT] <= almost_full_flag;
                        host_rdata_q[SFBC_EMPTY_FLAG_BIT] <= almost_empty_flag;
                        host_rdata_q[SFBC_THR_HI_BIT] <= thr_q[8];
                        host_rdata_q[SFBC_FILL_HI_BIT] <= size_small_q ? 1'b0 : count[8];
                        host_rdata_q[SFBC_FILL_TOP_BIT] <= size_small_q ? 1'b0 : count[9];
                    end
                    SFBC_THR_LOW_ADDR: host_rdata_q <= thr_q[7:0];
                    SFBC_FILL_ADDR: host_rdata_q <= count[7:0];
                    SFBC_DATA_ADDR: host_rdata_q <= out_valid ? out_data : 8'h00;
                    SFBC_INTERRUPT_STATUS_REG0_ADDR: begin
                        host_rdata_q[SFBC_IRQ_FULL_BIT] <= full_irq_q;
                        host_rdata_q[SFBC_IRQ_EMPTY_BIT] <= empty_irq_q;
                        host_rdata_q[SFBC_IRQ_ERR_BIT] <= err_irq_q;
                        host_rdata_q[SFBC_IRQ_OVR_BIT] <= overrun_q;
                    end
                    SFBC_INTERRUPT_STATUS_REG0_EN_ADDR: host_rdata_q <= irq_en_q;
                    default: host_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cmd_rdata_q <= 8'h00;
            cmd_rd_ok_q <= 1'b0;
            cmd_full_q <= 1'b0;
        end else begin
            cmd_rd_ok_q <= cmd_rd && !host_pop && out_valid && !clear;
            cmd_rdata_q <= out_data;
            cmd_full_q <= !in_ready;
        end
    end

    assign host_rdata = host_rdata_q;
    assign host_rvalid = host_rvalid_q;
    assign cmd_rdata = cmd_rdata_q;
    assign cmd_rd_ok = cmd_rd_ok_q;
    assign cmd_full = cmd_full_q;
    assign irq = irq_q;
endmodule

/* testbench/sfbc_assertions.sv */
`timescale 1ns/1ps
module sfbc_assertions
    import sfbc_pkg::*;
#(
    parameter int DEPTH = 512
) (
    input wire logic clock,
    input wire logic resetn,
    input wire sfbc_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_rd,
    input wire logic cmd_rd_ok,
    input wire logic [7:0] cmd_rdata,
    input wire logic cmd_full,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic any_wr;
    assign any_wr = cmd_wr || host_req.wr;
    read_answer_a: assert property (host_req.rd |=> host_rvalid)
        else $error("read strobe got no answer");
    answer_cause_a: assert property (host_rvalid |-> $past(host_req.rd))
        else $error("answer without a read");
    pop_cause_a: assert property (cmd_rd_ok |-> $past(cmd_rd))
        else $error("pop ok without a pop");
    reset_quiet_a: assert property ($rose(resetn) |-> !irq && !host_rvalid && !cmd_rd_ok && !cmd_full)
        else $error("outputs busy after reset");
    irq_masked_a: assert property ((host_req.wr && host_req.addr == SFBC_INTERRUPT_STATUS_REG0_EN_ADDR
        && host_req.wdata[3:1] == 3'h0) |=> ##1 !irq) else $error("irq with enables off");
    clear_empties_a: assert property ((host_req.wr && host_req.addr == SFBC_CTRL_ADDR
        && host_req.wdata[SFBC_CLEAR_BIT]) |-> ##[1:2] !cmd_full) else $error("full after clear");
    full_cause_a: assert property ($rose(cmd_full) |-> $past(any_wr) || $past(any_wr, 2)
        || $past(any_wr, 3)) else $error("full without a write");
    pop_when_full_a: assert property ((cmd_full && cmd_rd && !host_req.wr && !host_req.rd
        && !$past(host_req.wr)) |=> cmd_rd_ok) else $error("pop of full buffer refused");
endmodule
bind sfbc_top sfbc_assertions #(.DEPTH(DEPTH)) chk (.clock(clock), .resetn(resetn),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rd_ok(cmd_rd_ok), .cmd_rdata(cmd_rdata),
    .cmd_full(cmd_full), .irq(irq));

/* testbench/sfbc_host_model.sv */
`timescale 1ns/1ps
module sfbc_host_model
    import sfbc_pkg::*;
(
    input wire logic clock,
    output sfbc_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid
);
    initial host_req = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1 host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clock);
        #1 host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1 host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = host_rdata;
        ok = host_rvalid;
    endtask
endmodule

/* testbench/shared_fifo_buffer_control_bench.sv */
`timescale 1ns/1ps
module shared_fifo_buffer_control_bench
    import sfbc_pkg::*;
;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} sfbc_row_t;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_wdata = 8'h00;
    sfbc_req_t host_req;
    logic [7:0] host_rdata, cmd_rdata, rd;
    logic host_rvalid, cmd_rd_ok, cmd_full, irq, ok;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    sfbc_row_t rows[4] = '{'{8'h03, 8'h5a, 8'h5a}, '{8'h08, 8'h0e, 8'h0e},
        '{8'h01, 8'h55, 8'h00}, '{8'h03, 8'h00, 8'h00}};
    initial begin
        forever #2.5 clock = ~clock;
    end
    sfbc_top #(.DEPTH(512)) uut (.clock(clock), .resetn(resetn), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rd_ok(cmd_rd_ok),
        .cmd_rdata(cmd_rdata), .cmd_full(cmd_full), .irq(irq));
    sfbc_host_model host (.clock(clock), .host_req(host_req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid));
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.get(a, rd, ok);
        chk("read answer", 8'h01, {7'h00, ok});
        chk($sformatf("register %h", a), exp, rd);
    endtask
    // holding the strobe up gives one byte per cycle, back to back
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1 cmd_wr = 1'b1;
            cmd_wdata = i[7:0];
        end
        @(posedge clock);
        #1 cmd_wr = 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic pop(input logic [7:0] ok_e, input logic [7:0] d_e);
        @(posedge clock);
        #1 cmd_rd = 1'b1;
        @(posedge clock);
        #1 cmd_rd = 1'b0;
        chk("pop ok", ok_e, {7'h00, cmd_rd_ok});
        if (ok_e[0]) chk("pop data", d_e, cmd_rdata);
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        rchk(SFBC_THR_LOW_ADDR, 8'h08);
        rchk(SFBC_CTRL_ADDR, 8'h20);
        foreach (rows[i]) begin
            host.put(rows[i].a, rows[i].w);
            rchk(rows[i].a, rows[i].e);
        end
        host.put(SFBC_CTRL_ADDR, 8'h80);
        push(256);
        rchk(SFBC_FILL_ADDR, 8'hff);
        rchk(SFBC_CTRL_ADDR, 8'hc0);
        rchk(SFBC_INTERRUPT_STATUS_REG0_ADDR, 8'h0b);
        chk("irq", 8'h01, {7'h00, irq});
        chk("full", 8'h01, {7'h00, cmd_full});
        pop(8'h01, 8'h00);
        rchk(SFBC_DATA_ADDR, 8'h01);
        rchk(SFBC_FILL_ADDR, 8'hfd);
        host.put(SFBC_INTERRUPT_STATUS_REG0_EN_ADDR, 8'h00);
        host.put(SFBC_INTERRUPT_STATUS_REG0_ADDR, 8'h0f);
        // the overrun bit stays until a buffer clear
        rchk(SFBC_INTERRUPT_STATUS_REG0_ADDR, 8'h01);
        host.put(SFBC_INTERRUPT_STATUS_REG0_EN_ADDR, 8'h04);
        host.put(SFBC_CTRL_ADDR, 8'h90);
        repeat (3) @(posedge clock);
        #1;
        chk("irq", 8'h01, {7'h00, irq});
        chk("full", 8'h00, {7'h00, cmd_full});
        rchk(SFBC_FILL_ADDR, 8'h00);
        rchk(SFBC_DATA_ADDR, 8'h00);
        pop(8'h00, 8'h00);
        rchk(SFBC_FILL_ADDR, 8'h00);
        host.put(SFBC_CTRL_ADDR, 8'h14);
        push(256);
        rchk(SFBC_CTRL_ADDR, 8'h65);
        push(1);
        rchk(SFBC_CTRL_ADDR, 8'h45);
        rchk(SFBC_FILL_ADDR, 8'h01);
        push(255);
        chk("full", 8'h01, {7'h00, cmd_full});
        rchk(SFBC_CTRL_ADDR, 8'h46);
        rchk(SFBC_FILL_ADDR, 8'h00);
        // reset in mid-run with a full buffer and a raised pin
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        chk("full", 8'h00, {7'h00, cmd_full});
        chk("irq", 8'h00, {7'h00, irq});
        rchk(SFBC_FILL_ADDR, 8'h00);
        rchk(SFBC_THR_LOW_ADDR, 8'h08);
        print_verdict();
    end
endmodule
